// *** hdl/colc_count_buf.sv ***
`timescale 1ns/1ps
module colc_count_buf
    import colc_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         wr,
    input  wire logic [W-1:0] wdata,
    input  wire logic         enabled,
    input  wire logic         commit,
    output logic      [W-1:0] shadow_r,
    output logic      [W-1:0] work_r
);
    initial begin
        if (W < 1) begin
            $error("colc_count_buf width must be positive");
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow_r <= '0;
        end else if (wr) begin
            shadow_r <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            work_r <= '0;
        end else if (wr && !enabled) begin
            work_r <= wdata;
        end else if (commit) begin
            work_r <= shadow_r;
        end
    end

    chk_direct_load: assert property (@(posedge clk) disable iff (!rst_n)
        wr && !enabled |=> work_r == $past(wdata))
        else $error("Disabled write did not load working buffer");
    chk_held_until_load: assert property (@(posedge clk) disable iff (!rst_n)
        enabled && !commit |=> $stable(work_r))
        else $error("Working buffer changed without load");
endmodule : colc_count_buf

// *** hdl/colc_event_sel.sv ***
`timescale 1ns/1ps
module colc_event_sel
    import colc_pkg::*;
#(
    parameter int N = 7
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] src,
    input  wire logic [N-1:0] sel,
    input  wire logic [N-1:0] mode,
    output logic              event_r
);
    logic [N-1:0] src_d_r;
    logic [N-1:0] hit;

    // Mode bit high: edge sensitive, low: level
    always_comb begin
        hit = sel & ((mode & src & ~src_d_r) | (~mode & src));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_d_r <= '0;
        end else begin
            src_d_r <= src;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            event_r <= 1'b0;
        end else begin
            event_r <= |hit;
        end
    end

    chk_masked_src: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == '0) |=> !event_r)
        else $error("Event raised with no source enabled");
endmodule : colc_event_sel

// *** hdl/colc_pkg.sv ***
// Contract
// - Disabled: count writes reach working buffers immediately
// - Enabled: count writes wait for load request
// - Load request moves all counts together
// - Hardware clears load request after transfer
// - Outputs and fault routable to alternate pins
// - Generator keeps running during sleep
// - Internal oscillator kept on in sleep; here only while enabled with clock source CS_HFINT
// - Override levels programmed; start from shutdown
// - Auto-restart clears shutdown active by hardware
// - Independent source and mode selection per edge
// - Control 1 selects clock and dead-band sources; here the dead-band source bits are only stored and read back
// - Control 0 holds polarities and output enables
// - Shutdown sources separate from override levels
// - Rising select has seven source enable bits
package colc_pkg;
    localparam int          COLC_AW          = 6;
    localparam int          COLC_DW          = 8;
    localparam int          COLC_NSRC        = 7;
    localparam logic [5:0]  COLC_OFF_CON0    = 6'h00;
    localparam logic [5:0]  COLC_OFF_CON1    = 6'h04;
    localparam logic [5:0]  COLC_OFF_RIS     = 6'h08;
    localparam logic [5:0]  COLC_OFF_RSIM    = 6'h0c;
    localparam logic [5:0]  COLC_OFF_FIS     = 6'h10;
    localparam logic [5:0]  COLC_OFF_FSIM    = 6'h14;
    localparam logic [5:0]  COLC_OFF_ASD0    = 6'h18;
    localparam logic [5:0]  COLC_OFF_ASD1    = 6'h1c;
    localparam logic [5:0]  COLC_OFF_DBR     = 6'h20;
    localparam logic [5:0]  COLC_OFF_DBF     = 6'h24;
    localparam logic [5:0]  COLC_OFF_BKR     = 6'h28;
    localparam logic [5:0]  COLC_OFF_BKF     = 6'h2c;
    localparam logic [5:0]  COLC_OFF_PHR     = 6'h30;
    localparam logic [5:0]  COLC_OFF_PHF     = 6'h34;
    localparam logic [5:0]  COLC_OFF_APF     = 6'h38;
    localparam logic [5:0]  COLC_OFF_STAT    = 6'h3c;
    localparam int          CON0_EN          = 7;
    localparam int          CON0_LD          = 6;
    localparam int          CON0_POLB        = 4;
    localparam int          CON0_POLA        = 3;
    localparam int          CON0_OEB         = 1;
    localparam int          CON0_OEA         = 0;
    localparam int          CON1_CS_LO       = 0;
    localparam int          CON1_RDBS        = 7;
    localparam int          CON1_FDBS        = 6;
    localparam int          ASD0_ASDE        = 7;
    localparam int          ASD0_ARSEN       = 6;
    localparam int          ASD0_OVB_LO      = 4;
    localparam int          ASD0_OVA_LO      = 2;
    localparam int          APF_OUTA         = 0;
    localparam int          APF_OUTB         = 1;
    localparam int          APF_FLT          = 2;
    localparam logic [1:0]  CS_HFINT         = 2'h2;
    localparam logic [7:0]  RST_ZERO         = 8'h00;
    localparam logic [7:0]  RIS_MASK         = 8'h7f;
    localparam logic [7:0]  RST_ASD0         = 8'h00;
endpackage : colc_pkg

// *** hdl/colc_top.sv ***
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module colc_top
    import colc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [COLC_AW-1:0] avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic [6:0]         event_src,
    input  wire logic               fault_pin_main,
    input  wire logic               fault_pin_alt,
    input  wire logic               sleep_mode,
    output logic                    gen_output_a_main,
    output logic                    gen_output_a_alt,
    output logic                    gen_output_b_main,
    output logic                    gen_output_b_alt,
    output logic                    high_freq_osc_keep,
    output logic [7:0]              work_rise_deadband,
    output logic [7:0]              work_fall_deadband,
    output logic [7:0]              work_rise_blanking,
    output logic [7:0]              work_fall_blanking,
    output logic [7:0]              work_rise_phase,
    output logic [7:0]              work_fall_phase
);
    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic         ack_r;
    logic         wr_go;
    logic         rd_go;
    logic [7:0]   wb;
    logic [7:0]   gen_control_reg0_r;
    logic [7:0]   gen_control_reg1_r;
    logic [7:0]   rising_event_source_select_r;
    logic [7:0]   rising_event_mode_select_r;
    logic [7:0]   falling_event_source_select_r;
    logic [7:0]   falling_event_mode_select_r;
    logic [7:0]   shutdown_override_reg_r;
    logic [7:0]   shutdown_source_reg_r;
    logic [7:0]   alt_pin_function_reg_r;
    logic [7:0]   rd_nxt;
    logic         enabled;
    logic         load_req;
    logic         commit;
    logic [5:0]   cnt_wr;
    logic [7:0]   shadow [6];
    logic [7:0]   work [6];
    logic         rise_ev;
    logic         fall_ev;
    logic         fault_in;
    logic         shut_ev;
    logic         out_a_r;
    logic         out_b_r;
    logic         pin_a;
    logic         pin_b;

    assign wr_go           = avs_write && ack_r;
    assign rd_go           = avs_read && !ack_r;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign wb              = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    function automatic logic hit(input logic [5:0] off);
        return wr_go && avs_byteenable[0] && (avs_address == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Control and selection registers
    assign enabled  = gen_control_reg0_r[CON0_EN];
    assign load_req = gen_control_reg0_r[CON0_LD];
    assign commit   = load_req && enabled;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gen_control_reg0_r <= RST_ZERO;
        end else if (hit(COLC_OFF_CON0)) begin
            gen_control_reg0_r <= wb | {1'b0, load_req, 6'h00};
        end else if (commit) begin
            gen_control_reg0_r[CON0_LD] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gen_control_reg1_r <= RST_ZERO;
        end else if (hit(COLC_OFF_CON1)) begin
            gen_control_reg1_r <= wb;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rising_event_source_select_r <= RST_ZERO;
        end else if (hit(COLC_OFF_RIS)) begin
            rising_event_source_select_r <= wb & RIS_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rising_event_mode_select_r    <= RST_ZERO;
            falling_event_source_select_r <= RST_ZERO;
            falling_event_mode_select_r   <= RST_ZERO;
        end else begin
            if (hit(COLC_OFF_RSIM)) begin
                rising_event_mode_select_r <= wb & RIS_MASK;
            end
            if (hit(COLC_OFF_FIS)) begin
                falling_event_source_select_r <= wb & RIS_MASK;
            end
            if (hit(COLC_OFF_FSIM)) begin
                falling_event_mode_select_r <= wb & RIS_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shutdown_source_reg_r <= RST_ZERO;
        end else if (hit(COLC_OFF_ASD1)) begin
            shutdown_source_reg_r <= wb;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alt_pin_function_reg_r <= RST_ZERO;
        end else if (hit(COLC_OFF_APF)) begin
            alt_pin_function_reg_r <= wb;
        end
    end

    // Shutdown active: set by event wins over restart clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shutdown_override_reg_r <= RST_ASD0;
        end else if (hit(COLC_OFF_ASD0)) begin
            shutdown_override_reg_r <= wb | {shut_ev, 7'h00};
        end else if (shut_ev) begin
            shutdown_override_reg_r[ASD0_ASDE] <= 1'b1;
        end else if (enabled && shutdown_override_reg_r[ASD0_ARSEN]) begin
            shutdown_override_reg_r[ASD0_ASDE] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Double-buffered counts
    always_comb begin
        cnt_wr[0] = hit(COLC_OFF_DBR);
        cnt_wr[1] = hit(COLC_OFF_DBF);
        cnt_wr[2] = hit(COLC_OFF_BKR);
        cnt_wr[3] = hit(COLC_OFF_BKF);
        cnt_wr[4] = hit(COLC_OFF_PHR);
        cnt_wr[5] = hit(COLC_OFF_PHF);
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_cnt
            colc_count_buf #(
                .W (8)
            ) u_buf (
                .clk      (clk),
                .rst_n    (rst_n),
                .wr       (cnt_wr[gi]),
                .wdata    (wb),
                .enabled  (enabled),
                .commit   (commit),
                .shadow_r (shadow[gi]),
                .work_r   (work[gi])
            );
        end
    endgenerate

    assign work_rise_deadband = work[0];
    assign work_fall_deadband = work[1];
    assign work_rise_blanking = work[2];
    assign work_fall_blanking = work[3];
    assign work_rise_phase    = work[4];
    assign work_fall_phase    = work[5];

    ////////////////////////////////////////////////////////////////////////////
    // Events and outputs
    assign fault_in = alt_pin_function_reg_r[APF_FLT] ? fault_pin_alt
                                                      : fault_pin_main;

    colc_event_sel #(
        .N (COLC_NSRC)
    ) u_rise (
        .clk     (clk),
        .rst_n   (rst_n),
        .src     ({event_src[6:4], fault_in, event_src[2:0]}),
        .sel     (rising_event_source_select_r[6:0]),
        .mode    (rising_event_mode_select_r[6:0]),
        .event_r (rise_ev)
    );

    colc_event_sel #(
        .N (COLC_NSRC)
    ) u_fall (
        .clk     (clk),
        .rst_n   (rst_n),
        .src     ({event_src[6:4], fault_in, event_src[2:0]}),
        .sel     (falling_event_source_select_r[6:0]),
        .mode    (falling_event_mode_select_r[6:0]),
        .event_r (fall_ev)
    );

    assign shut_ev = enabled && |(shutdown_source_reg_r[6:0] &
                     {event_src[6:4], fault_in, event_src[2:0]});

    // Sleep is not gated in: clock and sources alone drive the logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_a_r <= 1'b0;
        end else if (!enabled) begin
            out_a_r <= 1'b0;
        end else if (rise_ev) begin
            out_a_r <= 1'b1;
        end else if (fall_ev) begin
            out_a_r <= 1'b0;
        end
    end

    assign out_b_r = !out_a_r;

    // Shutdown state drives override levels
    always_comb begin
        if (shutdown_override_reg_r[ASD0_ASDE] || !enabled) begin
            pin_a = shutdown_override_reg_r[ASD0_OVA_LO];
            pin_b = shutdown_override_reg_r[ASD0_OVB_LO];
        end else begin
            pin_a = out_a_r ^ gen_control_reg0_r[CON0_POLA];
            pin_b = out_b_r ^ gen_control_reg0_r[CON0_POLB];
        end
    end

    logic [3:0] pins_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_r <= 4'h0;
        end else begin
            pins_r[0] <= gen_control_reg0_r[CON0_OEA] && pin_a
                         && !alt_pin_function_reg_r[APF_OUTA];
            pins_r[1] <= gen_control_reg0_r[CON0_OEA] && pin_a
                         && alt_pin_function_reg_r[APF_OUTA];
            pins_r[2] <= gen_control_reg0_r[CON0_OEB] && pin_b
                         && !alt_pin_function_reg_r[APF_OUTB];
            pins_r[3] <= gen_control_reg0_r[CON0_OEB] && pin_b
                         && alt_pin_function_reg_r[APF_OUTB];
        end
    end
    assign gen_output_a_main = pins_r[0];
    assign gen_output_a_alt  = pins_r[1];
    assign gen_output_b_main = pins_r[2];
    assign gen_output_b_alt  = pins_r[3];

    assign high_freq_osc_keep = enabled && sleep_mode
        && (gen_control_reg1_r[CON1_CS_LO +: 2] == CS_HFINT);

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    always_comb begin
        case (avs_address)
            COLC_OFF_CON0: rd_nxt = gen_control_reg0_r;
            COLC_OFF_CON1: rd_nxt = gen_control_reg1_r;
            COLC_OFF_RIS:  rd_nxt = rising_event_source_select_r;
            COLC_OFF_RSIM: rd_nxt = rising_event_mode_select_r;
            COLC_OFF_FIS:  rd_nxt = falling_event_source_select_r;
            COLC_OFF_FSIM: rd_nxt = falling_event_mode_select_r;
            COLC_OFF_ASD0: rd_nxt = shutdown_override_reg_r;
            COLC_OFF_ASD1: rd_nxt = shutdown_source_reg_r;
            COLC_OFF_DBR:  rd_nxt = shadow[0];
            COLC_OFF_DBF:  rd_nxt = shadow[1];
            COLC_OFF_BKR:  rd_nxt = shadow[2];
            COLC_OFF_BKF:  rd_nxt = shadow[3];
            COLC_OFF_PHR:  rd_nxt = shadow[4];
            COLC_OFF_PHF:  rd_nxt = shadow[5];
            COLC_OFF_APF:  rd_nxt = alt_pin_function_reg_r;
            COLC_OFF_STAT: rd_nxt = {4'h0, out_b_r, out_a_r, fall_ev, rise_ev};
            default:       rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata <= {24'h00_0000, rd_nxt};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_load_clears: assert property (@(posedge clk) disable iff (!rst_n)
        commit && !hit(COLC_OFF_CON0) |=> !gen_control_reg0_r[CON0_LD])
        else $error("Load request not cleared after transfer");
    chk_load_moves: assert property (@(posedge clk) disable iff (!rst_n)
        commit && cnt_wr == 6'h00 |=> work[4] == $past(shadow[4])
                                   && work[0] == $past(shadow[0]))
        else $error("Counts not moved together on load");
    chk_ris_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        !rising_event_source_select_r[7])
        else $error("Rising select bit 7 not zero");
    chk_ris_reset: assert property (@(posedge clk)
        !rst_n |=> rising_event_source_select_r == 8'h00)
        else $error("Rising select not cleared by reset");
    chk_auto_restart: assert property (@(posedge clk) disable iff (!rst_n)
        enabled && shutdown_override_reg_r[ASD0_ARSEN] && !shut_ev
        && !hit(COLC_OFF_ASD0) |=> !shutdown_override_reg_r[ASD0_ASDE])
        else $error("Auto-restart did not clear shutdown active");
    chk_shut_override: assert property (@(posedge clk) disable iff (!rst_n)
        shutdown_override_reg_r[ASD0_ASDE] && gen_control_reg0_r[CON0_OEA]
        && !alt_pin_function_reg_r[APF_OUTA]
        |=> gen_output_a_main == $past(shutdown_override_reg_r[ASD0_OVA_LO]))
        else $error("Shutdown override level not driven");
    chk_osc_keep: assert property (@(posedge clk) disable iff (!rst_n)
        high_freq_osc_keep |-> enabled && sleep_mode)
        else $error("Oscillator held without enabled sleep");
    chk_alt_route: assert property (@(posedge clk) disable iff (!rst_n)
        alt_pin_function_reg_r[APF_OUTA] |=> !gen_output_a_main)
        else $error("Main pin driven while routed to alternate");
    chk_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
        avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("Read not answered in one cycle");

    cov_load: cover property (@(posedge clk) disable iff (!rst_n) commit);
    cov_restart: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(shutdown_override_reg_r[ASD0_ASDE]));
    cov_rise: cover property (@(posedge clk) disable iff (!rst_n) rise_ev);
endmodule : colc_top

// *** testbench/colc_partner.sv ***
`timescale 1ns/1ps
module colc_partner (
    input  wire logic       clk,
    input  wire logic [6:0] want_src,
    input  wire logic       want_fault,
    input  wire logic       slow,
    output logic      [6:0] event_src,
    output logic            fault_pin_main,
    output logic            fault_pin_alt
);
    logic [7:0] hold_r;
    ////////////////////////////////////////////////////////////////////////////////
    // Sources settle one or two cycles late; unused pin shows the inverse
    always_ff @(posedge clk) begin
        hold_r         <= {want_fault, want_src};
        event_src      <= slow ? hold_r[6:0] : want_src;
        fault_pin_main <= slow ? hold_r[7] : want_fault;
        fault_pin_alt  <= ~fault_pin_main;
    end
endmodule : colc_partner

// *** testbench/complementary_output_load_ctrl_bench.sv ***
`timescale 1ns/1ps
module complementary_output_load_ctrl_bench
    import colc_pkg::*;
;
    logic               clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [COLC_AW-1:0] avs_address;
    logic [31:0]        avs_writedata, avs_readdata;
    logic [3:0]         avs_byteenable;
    logic               sleep_mode, slow, want_fault, fault_pin_main, fault_pin_alt;
    logic [6:0]         event_src, want_src;
    logic               a_main, a_alt, b_main, b_alt, osc_keep;
    logic [7:0]         work [6];
    logic [7:0]         exp_work [6];
    logic [7:0]         vals [5];
    logic [5:0]         offs [5] = '{COLC_OFF_RIS, COLC_OFF_RSIM, COLC_OFF_FIS,
                                     COLC_OFF_FSIM, COLC_OFF_ASD1};
    logic [7:0]         rd;
    logic               exp_a;
    int                 err_count, total_checks, seed, i, k;
    ////////////////////////////////////////////////////////////////////////////////
    colc_top colc_top_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .event_src(event_src),
        .fault_pin_main(fault_pin_main), .fault_pin_alt(fault_pin_alt),
        .sleep_mode(sleep_mode), .gen_output_a_main(a_main), .gen_output_a_alt(a_alt),
        .gen_output_b_main(b_main), .gen_output_b_alt(b_alt),
        .high_freq_osc_keep(osc_keep), .work_rise_deadband(work[0]),
        .work_fall_deadband(work[1]), .work_rise_blanking(work[2]),
        .work_fall_blanking(work[3]), .work_rise_phase(work[4]), .work_fall_phase(work[5]));
    colc_partner colc_partner_inst (.clk(clk), .want_src(want_src), .want_fault(want_fault),
        .slow(slow), .event_src(event_src), .fault_pin_main(fault_pin_main),
        .fault_pin_alt(fault_pin_alt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    // Avalon request held until waitrequest is low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_read      <= !wr;
        avs_write     <= wr;
        n = 0;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                check_val("waitrequest", 8'h0, 8'h1);
                complete_run;
            end
            @(posedge clk);
        end
        rd = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check_val(what, exp, rd);
    endtask : rd_chk
    task automatic chk_work;
        for (int j = 0; j < 6; j++)
            check_val("work", exp_work[j], work[j]);
    endtask : chk_work
    task automatic wait_a(input logic exp);
        for (int n = 0; n < 12 && a_main !== exp; n++)
            @(negedge clk);
        @(negedge clk);
        check_val("out_a", {7'h0, exp}, {7'h0, a_main});
        check_val("out_b", {7'h0, !exp}, {7'h0, b_main});
    endtask : wait_a
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        check_val("run_length", 8'h0, 8'h1);
        complete_run;
    end
    initial begin
        seed = 32'h7baeebb2;
        {rst_n, avs_read, avs_write, sleep_mode, slow, want_fault} = '0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        want_src = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 16; i++)
            rd_chk("reset", 6'(4 * i), (i == 15) ? 8'h08 : 8'h00);
        bus(1'b1, COLC_OFF_RIS, 8'hff);
        rd_chk("ris", COLC_OFF_RIS, 8'h7f);
        bus(1'b1, 6'h02, 8'h55);
        rd_chk("unmapped", 6'h02, 8'h00);
        // Select, mode and shutdown source registers stay apart
        for (i = 0; i < 5; i++) begin
            vals[i] = 8'($random(seed)) & 8'h7f;
            bus(1'b1, offs[i], vals[i]);
        end
        for (i = 0; i < 5; i++)
            rd_chk("select", offs[i], vals[i]);
        bus(1'b1, COLC_OFF_ASD1, 8'h00);
        // Counts while disabled
        for (i = 0; i < 6; i++) begin
            exp_work[i] = 8'($random(seed));
            bus(1'b1, COLC_OFF_DBR + 6'(4 * i), exp_work[i]);
        end
        repeat (2) @(negedge clk);
        chk_work();
        // Start from shutdown with override levels
        bus(1'b1, COLC_OFF_ASD0, 8'h84);
        bus(1'b1, COLC_OFF_CON0, 8'h03);
        wait_a(1'b1);
        bus(1'b1, COLC_OFF_APF, 8'h01);
        repeat (3) @(negedge clk);
        check_val("alt_a", 8'h02, {6'h0, a_alt, a_main});
        bus(1'b1, COLC_OFF_APF, 8'h00);
        bus(1'b1, COLC_OFF_CON0, 8'h83);
        // Counts while enabled wait for the load request
        for (i = 0; i < 6; i++) begin
            vals[0] = 8'($random(seed));
            bus(1'b1, COLC_OFF_DBR + 6'(4 * i), vals[0]);
            rd_chk("shadow", COLC_OFF_DBR + 6'(4 * i), vals[0]);
            repeat (2) @(negedge clk);
            check_val("held", exp_work[i], work[i]);
            exp_work[i] = vals[0];
        end
        bus(1'b1, COLC_OFF_CON0, 8'hc3);
        repeat (2) @(negedge clk);
        chk_work();
        rd_chk("load_clear", COLC_OFF_CON0, 8'h83);
        // Oscillator kept for each clock source and sleep state
        for (i = 0; i < 8; i++) begin
            bus(1'b1, COLC_OFF_CON1, 8'(i % 4));
            @(posedge clk);
            sleep_mode <= i[2];
            @(negedge clk);
            check_val("osc_keep", {7'h0, i[2] && i % 4 == 2}, {7'h0, osc_keep});
            rd_chk("con1", COLC_OFF_CON1, 8'(i % 4));
        end
        // Auto restart leaves shutdown, in sleep from here on
        bus(1'b1, COLC_OFF_ASD0, 8'hc4);
        repeat (3) @(negedge clk);
        rd_chk("asd0", COLC_OFF_ASD0, 8'h44);
        bus(1'b1, COLC_OFF_RSIM, 8'h00);
        bus(1'b1, COLC_OFF_FSIM, 8'h00);
        bus(1'b1, COLC_OFF_FIS, 8'h02);
        bus(1'b1, COLC_OFF_RIS, 8'h01);
        exp_a = 1'b0;
        for (k = 0; k < 10; k++) begin
            @(posedge clk);
            want_src <= 7'($random(seed)) & 7'h03;
            slow <= k[0];
            @(posedge clk);
            if (want_src[0])
                exp_a = 1'b1;
            else if (want_src[1])
                exp_a = 1'b0;
            wait_a(exp_a);
        end
        // Disabled rising source has no effect
        @(posedge clk);
        want_src <= 7'h02;
        wait_a(1'b0);
        bus(1'b1, COLC_OFF_RIS, 8'h04);
        @(posedge clk);
        want_src <= 7'h01;
        repeat (10) @(negedge clk);
        check_val("masked", 8'h00, {7'h0, a_main});
        // Edge mode ignores a level that is already high
        bus(1'b1, COLC_OFF_RSIM, 8'h01);
        bus(1'b1, COLC_OFF_RIS, 8'h01);
        repeat (4) @(negedge clk);
        check_val("edge_mode", 8'h00, {7'h0, a_main});
        @(posedge clk);
        want_src <= 7'h00;
        repeat (6) @(posedge clk);
        want_src <= 7'h01;
        wait_a(1'b1);
        @(posedge clk);
        want_src <= 7'h02;
        wait_a(1'b0);
        // Alternate pins, fault taken from the alternate input
        bus(1'b1, COLC_OFF_RIS, 8'h08);
        bus(1'b1, COLC_OFF_APF, 8'h02);
        repeat (3) @(negedge clk);
        check_val("alt_b", 8'h08, {4'h0, b_alt, b_main, a_alt, a_main});
        bus(1'b1, COLC_OFF_APF, 8'h07);
        repeat (6) @(negedge clk);
        check_val("alt_flt", 8'h02, {4'h0, b_alt, b_main, a_alt, a_main});
        bus(1'b1, COLC_OFF_CON0, 8'h9b);
        repeat (3) @(negedge clk);
        check_val("polarity", 8'h08, {4'h0, b_alt, b_main, a_alt, a_main});
        complete_run;
    end
endmodule : complementary_output_load_ctrl_bench
